// File: design/coag_pkg.sv
// Package of constants and types for the operand address generator
package coag_pkg;

  // Address space and page zero
  localparam logic [15:0] PAGE0_LO = 16'h0000;
  localparam logic [15:0] PAGE0_HI = 16'h00FF;
  localparam logic [15:0] IDX_SHORT_HI = 16'h01FE;
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Mode field codes
  typedef enum logic [3:0] {
    COAG_INH = 4'h0,
    COAG_IMM = 4'h1,
    COAG_DIR_S = 4'h2,
    COAG_DIR_L = 4'h3,
    COAG_IDX_0 = 4'h4,
    COAG_IDX_S = 4'h5,
    COAG_IDX_L = 4'h6,
    COAG_IND_S = 4'h7,
    COAG_IND_L = 4'h8,
    COAG_IIX_S = 4'h9,
    COAG_IIX_L = 4'hA,
    COAG_REL_D = 4'hB,
    COAG_REL_I = 4'hC,
    COAG_BIT_D = 4'hD,
    COAG_BIT_I = 4'hE,
    COAG_BAD = 4'hF
  } coag_mode_t;

  // Sequencer states
  typedef enum logic [3:0] {
    COAG_IDLE = 4'h0,
    COAG_EXT1 = 4'h1,
    COAG_EXT2 = 4'h2,
    COAG_PTR1 = 4'h3,
    COAG_PTR2 = 4'h4,
    COAG_CALC = 4'h5,
    COAG_DONE = 4'h6
  } coag_state_t;

endpackage : coag_pkg

// File: design/coag_mode_dec.sv
// Opcode class decoder: addressing mode and operand length
`timescale 1ns/1ps
module coag_mode_dec (
  input wire logic [3:0] mode_sel,
  input wire logic rmw_op,
  output coag_pkg::coag_mode_t mode,
  output logic [1:0] ext_len,
  output logic [1:0] ptr_len,
  output logic illegal
);
  always_comb begin
    mode = coag_pkg::coag_mode_t'(mode_sel);
    illegal = 1'b0;
    // Read-modify-write ops take short forms only
    if (rmw_op && (mode == coag_pkg::COAG_DIR_L || mode == coag_pkg::COAG_IDX_L ||
        mode == coag_pkg::COAG_IND_L || mode == coag_pkg::COAG_IIX_L ||
        mode == coag_pkg::COAG_IMM)) begin
      illegal = 1'b1;
    end
    if (mode == coag_pkg::COAG_BAD) begin
      illegal = 1'b1;
    end
    unique case (mode)
      coag_pkg::COAG_INH, coag_pkg::COAG_IDX_0, coag_pkg::COAG_BAD: ext_len = 2'd0;
      coag_pkg::COAG_DIR_L, coag_pkg::COAG_IDX_L: ext_len = 2'd2;
      default: ext_len = 2'd1;
    endcase
    unique case (mode)
      coag_pkg::COAG_IND_S, coag_pkg::COAG_IIX_S, coag_pkg::COAG_REL_I, coag_pkg::COAG_BIT_I: ptr_len = 2'd1;
      coag_pkg::COAG_IND_L, coag_pkg::COAG_IIX_L: ptr_len = 2'd2;
      default: ptr_len = 2'd0;
    endcase
  end
endmodule : coag_mode_dec

// File: design/coag_ea_add.sv
// Effective address adder for each addressing mode
`timescale 1ns/1ps
module coag_ea_add (
  input coag_pkg::coag_mode_t mode,
  input wire logic [7:0] index,
  input wire logic [15:0] ext,
  input wire logic [15:0] ptr,
  input wire logic [15:0] pc,
  output logic [15:0] ea
);
  logic [15:0] rel_base;
  always_comb begin
    rel_base = (mode == coag_pkg::COAG_REL_I) ? ptr : ext;
    unique case (mode)
      coag_pkg::COAG_DIR_S, coag_pkg::COAG_BIT_D: ea = {8'h00, ext[7:0]};
      coag_pkg::COAG_DIR_L: ea = ext;
      coag_pkg::COAG_IDX_0: ea = {8'h00, index};
      coag_pkg::COAG_IDX_S: ea = {8'h00, index} + {8'h00, ext[7:0]};
      coag_pkg::COAG_IDX_L: ea = {8'h00, index} + ext;
      coag_pkg::COAG_IND_S, coag_pkg::COAG_BIT_I: ea = {8'h00, ptr[7:0]};
      coag_pkg::COAG_IND_L: ea = ptr;
      coag_pkg::COAG_IIX_S: ea = {8'h00, index} + {8'h00, ptr[7:0]};
      coag_pkg::COAG_IIX_L: ea = {8'h00, index} + ptr;
      coag_pkg::COAG_REL_D, coag_pkg::COAG_REL_I: ea = pc + {{8{rel_base[7]}}, rel_base[7:0]};
      default: ea = coag_pkg::RST_ADDR;
    endcase
  end
endmodule : coag_ea_add

// File: design/coag_top.sv
// Operand address generator: fetches operand bytes, pointers, forms addresses
// Operation
// - Short forms reach page zero, or up to 1FE when indexed, with fewer bytes and cycles.
// - Long forms reach the full 64 Kbyte space, with more bytes.
// - Read-modify-write instructions accept short addressing forms only.
// - Inherent instructions are one byte; no operand byte fetched.
// - Opcode alone selects operation and operands for inherent instructions.
// - Immediate instructions have one operand byte used as value.
// - Short direct fetches one address byte, reaching 00 to FF.
// - Long direct fetches a two-byte address word.
// - Indexed address is unsigned sum of chosen index and offset.
// - No-offset indexed fetches nothing; address is index alone.
// - Short indexed adds one offset byte, carry kept, up to 1FE.
// - Long indexed adds a two-byte offset word to index.
// - Indirect uses following byte as page-zero pointer address.
// - Short indirect pointer is one byte, address within 00 to FF.
// - Long indirect reads a two-byte pointer word starting in page zero; second byte at next address, no page wrap.
// - Indirect indexed adds index to pointer read from memory.
// - Short indirect indexed spans 00 to 1FE.
`timescale 1ns/1ps
module coag_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [3:0] mode_sel,
  input wire logic rmw_op,
  input wire logic use_y,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] x_reg,
  input wire logic [7:0] y_reg,
  input wire logic [15:0] pc_in,
  output logic mem_req,
  output logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  output logic busy,
  output logic done,
  output logic fault,
  output logic [15:0] op_addr,
  output logic op_addr_valid,
  output logic [7:0] imm_value,
  output logic imm_valid,
  output logic [2:0] bit_num,
  output logic [1:0] fetch_count
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and address arithmetic

  coag_pkg::coag_mode_t dec_mode;
  logic [1:0] dec_ext;
  logic [1:0] dec_ptr;
  logic dec_bad;
  coag_pkg::coag_mode_t mode;
  coag_pkg::coag_state_t state;
  logic [1:0] ext_len;
  logic [1:0] ptr_len;
  logic [7:0] index;
  logic [15:0] ext;
  logic [15:0] ptr;
  logic [15:0] pc;
  logic [15:0] ea;
  logic [15:0] fetch_pc;
  logic [2:0] bit_hold;

  coag_mode_dec u_dec (
    .mode_sel(mode_sel),
    .rmw_op(rmw_op),
    .mode(dec_mode),
    .ext_len(dec_ext),
    .ptr_len(dec_ptr),
    .illegal(dec_bad)
  );

  coag_ea_add u_add (
    .mode(mode),
    .index(index),
    .ext(ext),
    .ptr(ptr),
    .pc(pc),
    .ea(ea)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state <= coag_pkg::COAG_IDLE;
    end else begin
      unique case (state)
        coag_pkg::COAG_IDLE: begin
          if (start) begin
            if (dec_bad) begin
              state <= coag_pkg::COAG_DONE;
            end else if (dec_ext == 2'd0) begin
              state <= coag_pkg::COAG_CALC;
            end else begin
              state <= coag_pkg::COAG_EXT1;
            end
          end
        end
        coag_pkg::COAG_EXT1: begin
          if (mem_ack) begin
            if (ext_len == 2'd2) begin
              state <= coag_pkg::COAG_EXT2;
            end else if (ptr_len != 2'd0) begin
              state <= coag_pkg::COAG_PTR1;
            end else begin
              state <= coag_pkg::COAG_CALC;
            end
          end
        end
        coag_pkg::COAG_EXT2: begin
          if (mem_ack) begin
            state <= coag_pkg::COAG_CALC;
          end
        end
        coag_pkg::COAG_PTR1: begin
          if (mem_ack) begin
            state <= (ptr_len == 2'd2) ? coag_pkg::COAG_PTR2 : coag_pkg::COAG_CALC;
          end
        end
        coag_pkg::COAG_PTR2: begin
          if (mem_ack) begin
            state <= coag_pkg::COAG_CALC;
          end
        end
        coag_pkg::COAG_CALC: state <= coag_pkg::COAG_DONE;
        coag_pkg::COAG_DONE: state <= coag_pkg::COAG_IDLE;
        default: state <= coag_pkg::COAG_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction context capture

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode <= coag_pkg::COAG_INH;
      ext_len <= 2'd0;
      ptr_len <= 2'd0;
      index <= coag_pkg::RST_BYTE;
      pc <= coag_pkg::RST_ADDR;
      bit_hold <= 3'd0;
    end else if (state == coag_pkg::COAG_IDLE && start) begin
      mode <= dec_mode;
      ext_len <= dec_ext;
      ptr_len <= dec_ptr;
      index <= use_y ? y_reg : x_reg;
      pc <= pc_in;
      bit_hold <= bit_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand and pointer bytes, high byte first

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ext <= coag_pkg::RST_ADDR;
      ptr <= coag_pkg::RST_ADDR;
      fetch_pc <= coag_pkg::RST_ADDR;
    end else begin
      if (state == coag_pkg::COAG_IDLE && start) begin
        ext <= coag_pkg::RST_ADDR;
        ptr <= coag_pkg::RST_ADDR;
        fetch_pc <= pc_in + 16'h0001;
      end
      if (mem_ack && (state == coag_pkg::COAG_EXT1 || state == coag_pkg::COAG_EXT2)) begin
        ext <= {ext[7:0], mem_rdata};
        fetch_pc <= fetch_pc + 16'h0001;
      end
      if (mem_ack && (state == coag_pkg::COAG_PTR1 || state == coag_pkg::COAG_PTR2)) begin
        ptr <= {ptr[7:0], mem_rdata};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory port, shared by operand bytes and pointers

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_req <= 1'b0;
      mem_addr <= coag_pkg::RST_ADDR;
    end else if (mem_req && !mem_ack) begin
      mem_req <= 1'b1;
    end else begin
      mem_req <= 1'b0;
      if (state == coag_pkg::COAG_IDLE && start && !dec_bad && dec_ext != 2'd0) begin
        mem_req <= 1'b1;
        mem_addr <= pc_in + 16'h0001;
      end else if (state == coag_pkg::COAG_EXT1 && mem_ack && ext_len == 2'd2) begin
        mem_req <= 1'b1;
        mem_addr <= fetch_pc + 16'h0001;
      end else if (state == coag_pkg::COAG_EXT1 && mem_ack && ptr_len != 2'd0) begin
        mem_req <= 1'b1;
        mem_addr <= {8'h00, mem_rdata};
      end else if (state == coag_pkg::COAG_PTR1 && mem_ack && ptr_len == 2'd2) begin
        mem_req <= 1'b1;
        mem_addr <= mem_addr + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Results

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      fault <= 1'b0;
      op_addr <= coag_pkg::RST_ADDR;
      op_addr_valid <= 1'b0;
      imm_value <= coag_pkg::RST_BYTE;
      imm_valid <= 1'b0;
      bit_num <= 3'd0;
      fetch_count <= 2'd0;
    end else begin
      busy <= (state == coag_pkg::COAG_IDLE) ? (start == 1'b1) : (state != coag_pkg::COAG_DONE);
      done <= 1'b0;
      if (state == coag_pkg::COAG_IDLE && start) begin
        fault <= dec_bad;
        fetch_count <= dec_bad ? 2'd0 : dec_ext;
        op_addr_valid <= 1'b0;
        imm_valid <= 1'b0;
        if (dec_bad) begin
          done <= 1'b1;
        end
      end
      if (state == coag_pkg::COAG_CALC) begin
        done <= 1'b1;
        op_addr <= ea;
        op_addr_valid <= (mode != coag_pkg::COAG_INH && mode != coag_pkg::COAG_IMM);
        imm_valid <= (mode == coag_pkg::COAG_IMM);
        imm_value <= ext[7:0];
        bit_num <= bit_hold;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_inh_nofetch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_IDLE && start && !dec_bad && dec_ext == 2'd0)
    |=> !mem_req [*2])
    else $error("Fetch issued for a no-operand form");

  a_short_page0: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && (mode == coag_pkg::COAG_DIR_S || mode == coag_pkg::COAG_IND_S))
    |=> op_addr[15:8] == 8'h00)
    else $error("Short form left page zero");

  a_rmw_short: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_IDLE && start && rmw_op && mode_sel == 4'h3)
    |=> fault && done)
    else $error("Long form accepted for read-modify-write");

  a_idx_carry: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_IDX_S)
    |=> op_addr == {8'h00, index} + {8'h00, ext[7:0]} && op_addr <= coag_pkg::IDX_SHORT_HI)
    else $error("Short indexed sum wrong");

  a_ptr_page0: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_PTR1 && mem_req)
    |-> mem_addr[15:8] == 8'h00)
    else $error("Pointer read outside page zero");

  a_long_two: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_EXT2 && mem_ack)
    |=> state == coag_pkg::COAG_CALC ##1 done)
    else $error("Long fetch did not finish");

  a_rel_sign: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_REL_D)
    |=> op_addr == $past(pc) + {{8{$past(ext[7])}}, $past(ext[7:0])})
    else $error("Relative target wrong");

  a_addr_before: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(op_addr_valid)
    |-> done && $past(state) == coag_pkg::COAG_CALC)
    else $error("Address valid before calculation");

  a_req_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (mem_req && !mem_ack)
    |=> mem_req && $stable(mem_addr))
    else $error("Memory request dropped before acknowledge");

  a_done_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst)
    done
    |=> !done)
    else $error("Done held longer than one cycle");

  a_imm_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_IMM)
    |=> imm_valid && !op_addr_valid && imm_value == $past(ext[7:0]))
    else $error("Immediate value not presented");

  a_inh_flags: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_INH)
    |=> !imm_valid && !op_addr_valid)
    else $error("Inherent form flagged an operand");

  a_long_reach: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_DIR_L)
    |=> op_addr == $past(ext))
    else $error("Long direct address truncated");

  a_idx0_page0: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_IDX_0)
    |=> op_addr == {8'h00, $past(index)})
    else $error("No-offset indexed address wrong");

  a_iix_range: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && mode == coag_pkg::COAG_IIX_S)
    |=> op_addr <= coag_pkg::IDX_SHORT_HI)
    else $error("Short indirect indexed out of range");

  a_bit_page0: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_CALC && (mode == coag_pkg::COAG_BIT_D || mode == coag_pkg::COAG_BIT_I))
    |=> op_addr[15:8] == 8'h00 && bit_num == $past(bit_hold))
    else $error("Bit form operand or bit number wrong");

  a_fault_nofetch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_IDLE && start && dec_bad)
    |=> !mem_req && fault)
    else $error("Refused form started a fetch");

  a_req_fetching: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mem_req
    |-> (state == coag_pkg::COAG_EXT1 || state == coag_pkg::COAG_EXT2 || state == coag_pkg::COAG_PTR1 || state == coag_pkg::COAG_PTR2))
    else $error("Memory request outside a fetch state");

  a_short_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_IDLE && start && !dec_bad && (mode_sel == 4'h2 || mode_sel == 4'h5))
    |=> fetch_count == 2'd1)
    else $error("Short form byte count wrong");

  a_long_count: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_IDLE && start && !dec_bad && (mode_sel == 4'h3 || mode_sel == 4'h6))
    |=> fetch_count == 2'd2)
    else $error("Long form byte count wrong");

  a_ind_word: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (state == coag_pkg::COAG_PTR1 && mem_ack && ptr_len == 2'd2)
    |=> state == coag_pkg::COAG_PTR2 && mem_req && mem_addr == $past(mem_addr) + 16'h0001)
    else $error("Second pointer byte not requested");

endmodule : coag_top

// File: verification/coag_mem_model.sv
// Program and data memory model answering the operand fetch bus
`timescale 1ns/1ps
module coag_mem_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mem_req,
  input wire logic [15:0] mem_addr,
  input wire logic [3:0] ack_delay,
  output logic mem_ack,
  output logic [7:0] mem_rdata,
  output logic [7:0] ack_total
);

  ////////////////////////////////////////////////////////////////////////////
  // Memory contents as a fixed pattern of the address
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction : byte_at

  logic [3:0] wait_cnt;
  logic take;

  assign take = mem_req && !mem_ack && (wait_cnt >= ack_delay);

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge one byte per request, after a chosen wait
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
      ack_total <= 8'h00;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (take) begin
      mem_ack <= 1'b1;
      ack_total <= ack_total + 8'h01;
    end else if (mem_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end

  // Data only valid with the acknowledge, toggles otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mem_rdata <= 8'h5A;
    end else if (take) begin
      mem_rdata <= byte_at(mem_addr);
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

endmodule : coag_mem_model

// File: verification/coag_top_tb.sv
// Testbench of the operand address generator
`timescale 1ns/1ps
module coag_top_tb;
  typedef struct {logic [3:0] mode; logic rmw; logic use_y; logic [15:0] pc;} coag_row_t;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic rmw_op = 1'b0;
  logic use_y = 1'b0;
  logic [3:0] mode_sel = 4'h0;
  logic [3:0] ack_delay = 4'h0;
  logic [2:0] bit_sel = 3'h0;
  logic [7:0] x_reg = 8'hFF;
  logic [7:0] y_reg = 8'h80;
  logic [15:0] pc_in = 16'h0000;
  logic mem_req, mem_ack, busy, done, fault, op_addr_valid, imm_valid;
  logic [7:0] mem_rdata, ack_total, imm_value;
  logic [15:0] mem_addr, op_addr;
  logic [2:0] bit_num;
  logic [1:0] fetch_count;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int cyc[16];
  coag_row_t rows[$];

  always #5 sys_clk = ~sys_clk;

  coag_top coag_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .mode_sel(mode_sel),
    .rmw_op(rmw_op), .use_y(use_y), .bit_sel(bit_sel), .x_reg(x_reg), .y_reg(y_reg), .pc_in(pc_in),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .fault(fault), .op_addr(op_addr), .op_addr_valid(op_addr_valid), .imm_value(imm_value),
    .imm_valid(imm_valid), .bit_num(bit_num), .fetch_count(fetch_count));

  coag_mem_model coag_mem_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .ack_delay(ack_delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ack_total(ack_total));

  ////////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic end_sim;
    $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end

  function automatic logic [7:0] m(input logic [15:0] a);
    return coag_mem_model_i.byte_at(a);
  endfunction : m

  ////////////////////////////////////////////////////////////////////////////
  // One instruction: start, optional start while busy, wait for done, compare
  task automatic run(input coag_row_t r, input bit poke);
    logic [7:0] idx, b1, q, n0;
    logic [15:0] p, w, ea;
    logic flt;
    int n, fc, pb;
    idx = r.use_y ? y_reg : x_reg;
    b1 = m(r.pc + 16'h0001);
    p = {8'h00, b1};
    q = m(p);
    w = {q, m(p + 16'h0001)};
    flt = r.mode == 4'hF || (r.rmw && r.mode inside {4'h1, 4'h3, 4'h6, 4'h8, 4'hA});
    fc = r.mode inside {4'h0, 4'h4} ? 0 : r.mode inside {4'h3, 4'h6} ? 2 : 1;
    pb = r.mode inside {4'h7, 4'h9, 4'hC, 4'hE} ? 1 : r.mode inside {4'h8, 4'hA} ? 2 : 0;
    case (r.mode)
      4'h2, 4'hD: ea = {8'h00, b1};
      4'h3: ea = {b1, m(r.pc + 16'h0002)};
      4'h4: ea = {8'h00, idx};
      4'h5: ea = {8'h00, b1} + {8'h00, idx};
      4'h6: ea = {b1, m(r.pc + 16'h0002)} + {8'h00, idx};
      4'h7, 4'hE: ea = {8'h00, q};
      4'h8: ea = w;
      4'h9: ea = {8'h00, q} + {8'h00, idx};
      4'hA: ea = w + {8'h00, idx};
      4'hB: ea = r.pc + {{8{b1[7]}}, b1};
      4'hC: ea = r.pc + {{8{q[7]}}, q};
      default: ea = 16'h0000;
    endcase
    mode_sel = r.mode;
    rmw_op = r.rmw;
    use_y = r.use_y;
    pc_in = r.pc;
    bit_sel = r.pc[2:0];
    n0 = ack_total;
    start = 1'b1;
    @(posedge sys_clk) #1 start = 1'b0;
    if (poke && !flt) begin
      mode_sel = 4'hF;
      start = 1'b1;
      @(posedge sys_clk) #1 start = 1'b0;
    end
    n = 1;
    while (done !== 1'b1 && n < 40) begin
      @(posedge sys_clk) #1 n++;
    end
    chk("done", 16'h0001, {15'h0000, done});
    if (!flt) cyc[r.mode] = n;
    chk("fault", {15'h0000, flt}, {15'h0000, fault});
    chk("bus bytes", flt ? 16'h0000 : 16'(fc + pb), {8'h00, ack_total - n0});
    if (!flt) chk("fetch_count", 16'(fc), {14'h0000, fetch_count});
    if (!flt) chk("valid flags", {14'h0000, r.mode > 4'h1, r.mode == 4'h1},
      {14'h0000, op_addr_valid, imm_valid});
    if (!flt && r.mode > 4'h1)
      chk("op_addr", ea, op_addr);
    if (!flt && r.mode == 4'h1) chk("imm_value", {8'h00, b1}, {8'h00, imm_value});
    if (!flt && r.mode > 4'hC) chk("bit_num", {13'h0000, r.pc[2:0]}, {13'h0000, bit_num});
    @(posedge sys_clk) #1;
    chk("busy done", 16'h0000, {14'h0000, busy, done});
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 32; i++) begin
      rows.push_back('{i[3:0], i[4], i[0], 16'h1230 + 16'(i[3:0]) * 16'h0111});
    end
    rows.push_back('{4'h5, 1'b0, 1'b0, 16'h0059});
    repeat (3) @(posedge sys_clk);
    #1 sys_rst = 1'b0;
    chk("idle outputs", 16'h0000, {10'h000, busy, done, fault, mem_req, op_addr_valid, imm_valid});
    for (int d = 0; d < 2; d++) begin
      ack_delay = 4'(d * 3);
      foreach (rows[j]) begin
        run(rows[j], rows[j].mode == 4'h3);
      end
      chk("short faster", 16'h0001, 16'(cyc[2] < cyc[3] && cyc[5] < cyc[6]));
    end
    mode_sel = 4'h3;
    start = 1'b1;
    @(posedge sys_clk) #1 start = 1'b0;
    @(posedge sys_clk) #1 sys_rst = 1'b1;
    @(posedge sys_clk) #1 sys_rst = 1'b0;
    chk("reset outputs", 16'h0000, {10'h000, busy, done, fault, mem_req, op_addr_valid, imm_valid});
    run(rows[3], 1'b0);
    end_sim();
  end

endmodule : coag_top_tb
